//--- sac_pkg.sv
// constants, types and helpers for the sar conversion controller
// assumes one 125 MHz system clock; every host pin synchronous to it
package sac_pkg;

    localparam int RES_BITS_DEF      = 16;
    localparam int TRIM_W            = 4;
    localparam int BIT_TICKS         = 4;
    localparam int CONV_EXTRA        = 1;
    localparam int TCNT_W            = 8;
    localparam int CB_W              = 4;
    localparam int PH_W              = 2;
    localparam logic [PH_W-1:0] STEP_PH = 2'h3;
    localparam logic [CB_W-1:0] CAL_FIRST_BIT = 4'h1;

    // clock source timing
    localparam int CLK_SYS_MHZ       = 125;
    localparam int INT_OSC_PERIOD_NS = 250;
    localparam int INT_OSC_DIV       = (INT_OSC_PERIOD_NS * CLK_SYS_MHZ + 999) / 1000;
    localparam int DIV_W             = 6;
    localparam int MCLK_LOSS_NS      = 12000;
    localparam int MCLK_LOSS_CYC     = (MCLK_LOSS_NS * CLK_SYS_MHZ) / 1000;
    localparam int LOSS_W            = 11;

    typedef enum logic [1:0] {
        SAC_CAL,
        SAC_TRACK,
        SAC_CONV
    } sac_state_e;

    // conversion length in master clock ticks
    function automatic logic [TCNT_W-1:0] conv_ticks(input int bits);
        return TCNT_W'(BIT_TICKS * bits + CONV_EXTRA);
    endfunction

    // out of range clamp of a finished code
    function automatic logic [RES_BITS_DEF-1:0] clamp_code(
        input logic [RES_BITS_DEF-1:0] code,
        input logic                    hi,
        input logic                    lo);
        if (hi) begin
            return '1;
        end
        if (lo) begin
            return '0;
        end
        return code;
    endfunction

endpackage

//--- sac_ctl_if.sv
// latched host control passed from the pin latch to the core
// assumes both ends on clk_sys
`timescale 1ns/1ns
interface sac_ctl_if;
    logic cal_lat;
    logic interleave_ctl_n_n_lat;
    logic cs_end;
    logic soft_rst;
    modport src (output cal_lat, output interleave_ctl_n_n_lat, output cs_end, output soft_rst);
    modport dst (input cal_lat, input interleave_ctl_n_n_lat, input cs_end, input soft_rst);
endinterface

//--- sac_sar.sv
// generic successive approximation register, msb first
// assumes step comes at most once a cycle, after start
`timescale 1ns/1ns
module sac_sar #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // control
    input  wire logic         start,
    input  wire logic         step,
    input  wire logic         above,
    // state
    output logic [W-1:0]      trial_q,
    output logic              done_q
);
    localparam logic [W-1:0] TOP = {1'b1, {(W-1){1'b0}}};

    logic [W-1:0] trial_d;
    logic [W-1:0] mask_q;
    logic [W-1:0] mask_d;
    logic         done_d;

    always_comb begin
        trial_d = trial_q;
        mask_d  = mask_q;
        done_d  = done_q;
        if (start) begin
            trial_d = TOP;
            mask_d  = TOP;
            done_d  = 1'b0;
        end else if (step && !done_q) begin
            if (!above) begin
                trial_d = trial_q & ~mask_q;
            end
            mask_d  = mask_q >> 1;
            trial_d = trial_d | (mask_q >> 1);
            if (mask_q[0]) begin
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            trial_q <= '0;
            mask_q  <= '0;
            done_q  <= 1'b0;
        end else begin
            trial_q <= trial_d;
            mask_q  <= mask_d;
            done_q  <= done_d;
        end
    end
endmodule

//--- sac_ctl_latch.sv
// chip select control latch and software reset detector
// assumes host pins synchronous to clk_sys
`timescale 1ns/1ns
module sac_ctl_latch import sac_pkg::*; (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // host pins
    input  wire logic cs_n,
    input  wire logic addr_bit_zero,
    input  wire logic hold_n,
    input  wire logic cal_in,
    input  wire logic interleave_ctl_n,
    // to core
    sac_ctl_if.src    ctl
);
    logic cs_q;
    logic cs_d;
    logic cal_q;
    logic cal_d;
    logic interleave_ctl_n_q;
    logic interleave_ctl_n_d;
    logic end_q;
    logic end_d;
    logic low_q;
    logic low_d;
    logic soft_q;
    logic soft_d;

    always_comb begin
        cs_d     = cs_n;
        // transparent while selected, frozen when select returns high
        cal_d    = cs_n ? cal_q : cal_in;
        interleave_ctl_n_d = cs_n ? interleave_ctl_n_q : interleave_ctl_n;
        end_d    = cs_n && !cs_q;
        low_d    = !cs_n && !addr_bit_zero && !hold_n;
        soft_d   = low_d && !low_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cs_q     <= 1'b1;
            cal_q    <= 1'b0;
            interleave_ctl_n_q <= 1'b1;
            end_q    <= 1'b0;
            low_q    <= 1'b0;
            soft_q   <= 1'b0;
        end else begin
            cs_q     <= cs_d;
            cal_q    <= cal_d;
            interleave_ctl_n_q <= interleave_ctl_n_d;
            end_q    <= end_d;
            low_q    <= low_d;
            soft_q   <= soft_d;
        end
    end

    assign ctl.cal_lat      = cal_q;
    assign ctl.interleave_ctl_n_n_lat = interleave_ctl_n_q;
    assign ctl.cs_end       = end_q;
    assign ctl.soft_rst     = soft_q;
endmodule

//--- sac_conv_ctl.sv
// top of the sar conversion and calibration controller
// assumes analog comparator and range flags settle within one tick
`timescale 1ns/1ns
module sac_conv_ctl import sac_pkg::*; #(
    parameter int RES_BITS = RES_BITS_DEF
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // master clock pin
    input  wire logic                master_clock_in,
    // host control pins
    input  wire logic                cs_n,
    input  wire logic                addr_bit_zero,
    input  wire logic                hold_n,
    input  wire logic                cal_in,
    input  wire logic                interleave_ctl_n,
    // configuration
    input  wire logic                bipolar_mode,
    // analog side
    input  wire logic                comp_above,
    input  wire logic                over_range_hi,
    input  wire logic                under_range_lo,
    // array switch control
    output logic                     tracking_switch_q,
    output logic                     array_to_input_q,
    output logic                     msb_to_ref_q,
    output logic                     autozero_q,
    output logic [RES_BITS-1:0]      dac_code_q,
    output logic [CB_W-1:0]          cal_bit_q,
    output logic [TRIM_W-1:0]        cal_trim_q,
    // status and result
    output logic [RES_BITS-1:0]      result_q,
    output logic                     eoc_n_q,
    output logic                     converting_q,
    output logic                     calibrating_q
);
    localparam logic [TCNT_W-1:0] CONV_T    = conv_ticks(RES_BITS);
    localparam logic [TCNT_W-1:0] STEP_T    = TCNT_W'(BIT_TICKS * RES_BITS);
    localparam logic [CB_W-1:0]   CAL_LAST  = CB_W'(RES_BITS - 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(INT_OSC_DIV - 1);
    localparam logic [LOSS_W-1:0] LOSS_LIM  = LOSS_W'(MCLK_LOSS_CYC);

    // clock source and tick generation
    logic               mclk_q;
    logic               mclk_d;
    logic               ext_mode_q;
    logic               ext_mode_d;
    logic               tick_q;
    logic               tick_d;
    logic [DIV_W-1:0]   div_q;
    logic [DIV_W-1:0]   div_d;
    logic [LOSS_W-1:0]  loss_q;
    logic [LOSS_W-1:0]  loss_d;
    logic               mclk_rise;

    always_comb begin
        mclk_d    = master_clock_in;
        mclk_rise = master_clock_in && !mclk_q;
        div_d     = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
        if (master_clock_in) begin
            loss_d = '0;
        end else if (loss_q == LOSS_LIM) begin
            loss_d = loss_q;
        end else begin
            loss_d = loss_q + 1'b1;
        end
        ext_mode_d = ext_mode_q;
        if (mclk_rise) begin
            ext_mode_d = 1'b1;
        end else if (loss_q == LOSS_LIM) begin
            ext_mode_d = 1'b0;
        end
        tick_d = ext_mode_q ? mclk_rise : (div_q == '0);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mclk_q     <= 1'b0;
            ext_mode_q <= 1'b0;
            tick_q     <= 1'b0;
            div_q      <= '0;
            loss_q     <= '0;
        end else begin
            mclk_q     <= mclk_d;
            ext_mode_q <= ext_mode_d;
            tick_q     <= tick_d;
            div_q      <= div_d;
            loss_q     <= loss_d;
        end
    end

    // host control latch
    sac_ctl_if ctl ();

    sac_ctl_latch u_latch (
        .clk_sys          (clk_sys),
        .rst_b            (rst_b),
        .cs_n             (cs_n),
        .addr_bit_zero    (addr_bit_zero),
        .hold_n           (hold_n),
        .cal_in           (cal_in),
        .interleave_ctl_n (interleave_ctl_n),
        .ctl              (ctl.src)
    );

    // search engines
    logic                conv_start;
    logic                conv_step;
    logic [RES_BITS-1:0] conv_trial;
    logic                cal_start;
    logic                cal_step;
    logic [TRIM_W-1:0]   trim_trial;
    logic                trim_done;

    sac_sar #(.W(RES_BITS)) u_conv_sar (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .start   (conv_start),
        .step    (conv_step),
        .above   (comp_above),
        .trial_q (conv_trial),
        .done_q  ()
    );

    // heavier bit side lowers the trim
    sac_sar #(.W(TRIM_W)) u_trim_sar (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .start   (cal_start),
        .step    (cal_step),
        .above   (!comp_above),
        .trial_q (trim_trial),
        .done_q  (trim_done)
    );

    // sequencer
    sac_state_e          state_q;
    sac_state_e          state_d;
    logic [TCNT_W-1:0]   tcnt_q;
    logic [TCNT_W-1:0]   tcnt_d;
    logic [CB_W-1:0]     cal_bit_d;
    logic                cal_pend_q;
    logic                cal_pend_d;
    logic [TRIM_W-1:0]   trim_q [RES_BITS];
    logic [TRIM_W-1:0]   trim_d [RES_BITS];
    logic [RES_BITS-1:0] result_d;
    logic                eoc_n_d;
    logic                hold_q;
    logic                hold_fall;
    logic                phase_hit;
    logic                boot_q;

    always_comb begin
        state_d    = state_q;
        tcnt_d     = tcnt_q;
        cal_bit_d  = cal_bit_q;
        cal_pend_d = cal_pend_q;
        trim_d     = trim_q;
        result_d   = result_q;
        eoc_n_d    = eoc_n_q;
        conv_start = 1'b0;
        cal_start  = boot_q;
        hold_fall  = hold_q && !hold_n;
        phase_hit  = tick_q && (tcnt_q[PH_W-1:0] == STEP_PH);
        conv_step  = (state_q == SAC_CONV) && phase_hit && (tcnt_q < STEP_T);
        cal_step   = (state_q == SAC_CAL) && phase_hit;
        if (state_q == SAC_CAL && tick_q) begin
            tcnt_d = tcnt_q + 1'b1;
        end
        if (ctl.cs_end && ctl.cal_lat && state_q != SAC_CAL) begin
            cal_pend_d = 1'b1;
        end
        if (ctl.soft_rst) begin
            state_d    = SAC_CAL;
            cal_bit_d  = CAL_FIRST_BIT;
            cal_start  = 1'b1;
            cal_pend_d = 1'b0;
            tcnt_d     = '0;
            eoc_n_d    = 1'b1;
        end else begin
            case (state_q)
                SAC_TRACK: begin
                    if (hold_fall) begin
                        state_d    = SAC_CONV;
                        tcnt_d     = '0;
                        conv_start = 1'b1;
                        eoc_n_d    = 1'b1;
                    end else if (cal_pend_q) begin
                        state_d    = SAC_CAL;
                        cal_start  = 1'b1;
                        cal_pend_d = 1'b0;
                        tcnt_d     = '0;
                        eoc_n_d    = 1'b1;
                    end
                end
                SAC_CONV: begin
                    if (tick_q) begin
                        tcnt_d = tcnt_q + 1'b1;
                    end
                    if (tick_q && tcnt_q == '0) begin
                        eoc_n_d = 1'b1;
                    end
                    if (tick_q && tcnt_q == CONV_T) begin
                        result_d = RES_BITS'(clamp_code(RES_BITS_DEF'(conv_trial),
                                   over_range_hi, under_range_lo));
                        eoc_n_d  = 1'b0;
                        tcnt_d   = '0;
                        if (!hold_n) begin
                            conv_start = 1'b1;
                        end else if (cal_pend_q) begin
                            state_d    = SAC_CAL;
                            cal_start  = 1'b1;
                            cal_pend_d = 1'b0;
                        end else begin
                            state_d = SAC_TRACK;
                        end
                    end
                end
                SAC_CAL: begin
                    if (ctl.cs_end && !ctl.cal_lat) begin
                        state_d = SAC_TRACK;
                        eoc_n_d = 1'b0;
                    end else if (!ctl.interleave_ctl_n_n_lat && hold_fall) begin
                        state_d    = SAC_CONV;
                        tcnt_d     = '0;
                        conv_start = 1'b1;
                        cal_pend_d = 1'b1;
                    end else if (trim_done && !cal_start) begin
                        trim_d[cal_bit_q] = trim_trial;
                        tcnt_d            = '0;
                        if (cal_bit_q == CAL_LAST) begin
                            state_d = SAC_TRACK;
                            eoc_n_d = 1'b0;
                        end else begin
                            cal_bit_d = cal_bit_q + 1'b1;
                            cal_start = 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = SAC_TRACK;
                end
            endcase
        end
    end

    // track switches follow the next state, dac code and trim the current one
    logic                trk_d;
    logic [RES_BITS-1:0] dac_d;
    logic [TRIM_W-1:0]   ctrim_d;

    always_comb begin
        trk_d = (state_d == SAC_TRACK);
        case (state_q)
            SAC_CONV: begin
                dac_d = conv_trial;
            end
            SAC_CAL: begin
                dac_d = RES_BITS'(1) << cal_bit_q;
            end
            default: begin
                dac_d = '0;
            end
        endcase
        ctrim_d = (state_q == SAC_CAL) ? trim_trial : trim_q[cal_bit_q];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q           <= SAC_CAL;
            tcnt_q            <= '0;
            cal_bit_q         <= CAL_FIRST_BIT;
            cal_pend_q        <= 1'b0;
            for (int i = 0; i < RES_BITS; i++) begin
                trim_q[i] <= '0;
            end
            result_q          <= '0;
            eoc_n_q           <= 1'b1;
            hold_q            <= 1'b1;
            tracking_switch_q <= 1'b0;
            array_to_input_q  <= 1'b0;
            msb_to_ref_q      <= 1'b0;
            autozero_q        <= 1'b0;
            dac_code_q        <= '0;
            cal_trim_q        <= '0;
            converting_q      <= 1'b0;
            calibrating_q     <= 1'b1;
        end else begin
            state_q           <= state_d;
            tcnt_q            <= tcnt_d;
            cal_bit_q         <= cal_bit_d;
            cal_pend_q        <= cal_pend_d;
            trim_q            <= trim_d;
            result_q          <= result_d;
            eoc_n_q           <= eoc_n_d;
            hold_q            <= hold_n;
            tracking_switch_q <= trk_d;
            array_to_input_q  <= trk_d;
            msb_to_ref_q      <= trk_d && bipolar_mode;
            autozero_q        <= trk_d;
            dac_code_q        <= dac_d;
            cal_trim_q        <= ctrim_d;
            converting_q      <= (state_d == SAC_CONV);
            calibrating_q     <= (state_d == SAC_CAL);
        end
    end

    // power-on calibration starts its engine on the first cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end
endmodule

//--- sac_conv_ctl_dummy_end.sv
// intentionally empty
`timescale 1ns/1ns

//--- sac_conv_ctl_monitor.sv
// port checker for the sar conversion controller
// assumes bound into sac_conv_ctl, one clock domain
`timescale 1ns/1ns
module sac_conv_ctl_monitor import sac_pkg::*; #(
    parameter int RES_BITS = RES_BITS_DEF
) (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_b,
    // host pins
    input wire logic                cs_n,
    input wire logic                addr_bit_zero,
    input wire logic                hold_n,
    input wire logic                cal_in,
    input wire logic                bipolar_mode,
    // switch and status outputs
    input wire logic                tracking_switch_q,
    input wire logic                array_to_input_q,
    input wire logic                msb_to_ref_q,
    input wire logic                autozero_q,
    input wire logic [RES_BITS-1:0] dac_code_q,
    input wire logic [CB_W-1:0]     cal_bit_q,
    input wire logic                eoc_n_q,
    input wire logic                converting_q,
    input wire logic                calibrating_q
);
    localparam int CONV_MAX = (4 * RES_BITS + 6) * 32;
    localparam logic [RES_BITS-1:0] MSB_ONLY = {1'b1, {(RES_BITS - 1){1'b0}}};
    logic [15:0] conv_cyc_q;
    logic [15:0] conv_cyc_d;
    logic        idle;
    logic        srst;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    assign idle = !converting_q && !calibrating_q;
    assign srst = !cs_n && !addr_bit_zero && !hold_n;
    // cycles spent in one conversion
    always_comb begin
        conv_cyc_d = (converting_q && eoc_n_q) ? conv_cyc_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            conv_cyc_q <= 16'h0000;
        end else begin
            conv_cyc_q <= conv_cyc_d;
        end
    end
    sequence s_sel_done;
        $rose(cs_n) && $past(hold_n) && !converting_q;
    endsequence
    sequence s_cal_on;
        ##[1:4] calibrating_q;
    endsequence
    sequence s_cal_off;
        ##[1:4] (!calibrating_q && !eoc_n_q);
    endsequence
    a_track_when_idle:
        assert property (idle && $past(idle) |-> tracking_switch_q && array_to_input_q)
        else $error("array not tracking while idle");
    a_switch_opens:
        assert property (converting_q && $past(converting_q) |-> !tracking_switch_q)
        else $error("tracking switch closed in conversion");
    a_autozero_track:
        assert property (autozero_q == tracking_switch_q)
        else $error("offset store phase differs from track");
    a_msb_on_ref:
        assert property (msb_to_ref_q |-> tracking_switch_q && $past(bipolar_mode))
        else $error("msb on reference outside bipolar track");
    a_hold_starts_conv:
        assert property (idle && cs_n && $past(hold_n) && !hold_n |=> converting_q)
        else $error("hold fall did not start conversion");
    a_first_trial_msb:
        assert property ($rose(converting_q) |=> dac_code_q == MSB_ONLY)
        else $error("first trial not half scale");
    a_conv_bounded:
        assert property (conv_cyc_q <= CONV_MAX)
        else $error("conversion too long");
    a_soft_reset_cal:
        assert property (srst && !$past(srst) |-> ##[1:2]
            (calibrating_q && eoc_n_q && cal_bit_q == CAL_FIRST_BIT))
        else $error("software reset did not restart calibration");
    a_sel_ends_cal:
        assert property (s_sel_done and (!$past(cal_in) && calibrating_q) |-> s_cal_off)
        else $error("select cycle did not end calibration");
    a_sel_starts_cal:
        assert property (s_sel_done and ($past(cal_in) && !calibrating_q) |-> s_cal_on)
        else $error("select cycle did not start calibration");
    a_cal_bit_range:
        assert property (calibrating_q |-> cal_bit_q >= CAL_FIRST_BIT && cal_bit_q < RES_BITS)
        else $error("calibrated bit out of range");
endmodule
bind sac_conv_ctl sac_conv_ctl_monitor #(.RES_BITS(RES_BITS)) u_sac_conv_ctl_monitor (
    .clk_sys, .rst_b, .cs_n, .addr_bit_zero, .hold_n, .cal_in, .bipolar_mode,
    .tracking_switch_q, .array_to_input_q, .msb_to_ref_q, .autozero_q, .dac_code_q,
    .cal_bit_q, .eoc_n_q, .converting_q, .calibrating_q
);

//--- sac_host_model.sv
// host side model: master clock source and sample trigger pin
// assumes drive_hold is called just after a rising clk_sys edge
`timescale 1ns/1ns
module sac_host_model (
    // clock
    input  wire logic clk_sys,
    // mode from bench
    input  wire logic ext_en,
    // pins to the converter
    output logic      master_clock_in,
    output logic      hold_n
);
    logic [1:0] ph_q;
    initial begin
        ph_q = 2'h0;
        hold_n = 1'b1;
    end
    always @(posedge clk_sys) begin
        ph_q <= #1 ph_q + 2'h1;
    end
    // held low selects the internal oscillator
    assign master_clock_in = ext_en & ph_q[1];
    // trigger changes just after an edge only
    task automatic drive_hold(input logic v);
        @(posedge clk_sys);
        #1 hold_n = v;
    endtask
endmodule

//--- sac_conv_ctl_tb.sv
// self-checking bench for the sar conversion controller
// assumes host model for clock and trigger, comparator modelled here
`timescale 1ns/1ns
module sac_conv_ctl_tb import sac_pkg::*;;
    localparam int RB = 12;
    logic              clk_sys, rst_b, master_clock_in, cs_n, addr_bit_zero, hold_n;
    logic              cal_in, interleave_ctl_n, bipolar_mode, comp_above;
    logic              over_range_hi, under_range_lo, ext_en;
    logic              tracking_switch_q, array_to_input_q, msb_to_ref_q, autozero_q;
    logic              eoc_n_q, converting_q, calibrating_q;
    logic [RB-1:0]     dac_code_q, result_q, vin;
    logic [CB_W-1:0]   cal_bit_q;
    logic [TRIM_W-1:0] cal_trim_q;
    int                n_fail, num_checks;
    sac_conv_ctl #(.RES_BITS(RB)) u_sac_conv_ctl (
        .clk_sys, .rst_b, .master_clock_in, .cs_n, .addr_bit_zero, .hold_n, .cal_in,
        .interleave_ctl_n, .bipolar_mode, .comp_above, .over_range_hi, .under_range_lo,
        .tracking_switch_q, .array_to_input_q, .msb_to_ref_q, .autozero_q, .dac_code_q,
        .cal_bit_q, .cal_trim_q, .result_q, .eoc_n_q, .converting_q, .calibrating_q
    );
    sac_host_model u_sac_host_model (.clk_sys, .ext_en, .master_clock_in, .hold_n);
    assign comp_above = (vin >= dac_code_q);
    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return eoc_n_q;
            1: return calibrating_q;
            default: return converting_q;
        endcase
    endfunction
    task automatic wait_on(input int w, input logic v, input int lim, output int c);
        c = 0;
        while (sig(w) !== v) begin
            cyc(1);
            c++;
            if (c > lim) begin
                chk(12'(sig(w)), 12'(v));
                close_out();
            end
        end
    endtask
    task automatic sel(input logic cal);
        cs_n = 1'b0;
        cal_in = cal;
        cyc(2);
        cs_n = 1'b1;
        cyc(1);
    endtask
    task automatic t_start();
        int c;
        chk(12'(calibrating_q), 12'h1);
        chk(12'(eoc_n_q), 12'h1);
        sel(1'b0);
        wait_on(1, 1'b0, 8, c);
        cyc(2);
        chk(12'(tracking_switch_q), 12'h1);
        chk(12'(array_to_input_q), 12'h1);
        chk(12'(autozero_q), 12'h1);
        chk(12'(msb_to_ref_q), 12'h0);
        chk(12'(eoc_n_q), 12'h0);
    endtask
    task automatic t_conv(input logic [11:0] v, input logic bip, input logic hi,
                          input logic lo, input logic [11:0] ev, input int tpc);
        int c;
        vin = v;
        bipolar_mode = bip;
        over_range_hi = hi;
        under_range_lo = lo;
        cyc(2);
        u_sac_host_model.drive_hold(1'b0);
        cyc(2);
        chk(12'(converting_q), 12'h1);
        chk(12'(tracking_switch_q), 12'h0);
        chk(12'(eoc_n_q), 12'h1);
        cyc(tpc + 6);
        u_sac_host_model.drive_hold(1'b1);
        wait_on(0, 1'b0, 60 * tpc, c);
        chk(result_q, ev);
        c = c + tpc + 9;
        chk(12'(c >= 49 * tpc && c <= 50 * tpc + 4), 12'h1);
        cyc(2);
        chk(12'(tracking_switch_q), 12'h1);
        chk(12'(msb_to_ref_q), 12'(bip));
        cyc(8);
    endtask
    task automatic t_reconv();
        int c;
        vin = 12'h456;
        over_range_hi = 1'b0;
        under_range_lo = 1'b0;
        u_sac_host_model.drive_hold(1'b0);
        cyc(3);
        wait_on(0, 1'b0, 240, c);
        chk(result_q, 12'h456);
        vin = 12'h9B6;
        cyc(2);
        chk(12'(converting_q), 12'h1);
        chk(12'(tracking_switch_q), 12'h0);
        u_sac_host_model.drive_hold(1'b1);
        wait_on(0, 1'b1, 8, c);
        wait_on(0, 1'b0, 240, c);
        chk(result_q, 12'h9B6);
        cyc(8);
    endtask
    task automatic t_cal_sel();
        int c;
        sel(1'b1);
        wait_on(1, 1'b1, 8, c);
        chk(12'(eoc_n_q), 12'h1);
        u_sac_host_model.drive_hold(1'b0);
        cyc(3);
        chk(12'(converting_q), 12'h0);
        u_sac_host_model.drive_hold(1'b1);
        interleave_ctl_n = 1'b0;
        sel(1'b1);
        vin = 12'h2D7;
        u_sac_host_model.drive_hold(1'b0);
        cyc(2);
        chk(12'(converting_q), 12'h1);
        cyc(8);
        u_sac_host_model.drive_hold(1'b1);
        wait_on(1, 1'b1, 240, c);
        chk(result_q, 12'h2D7);
        interleave_ctl_n = 1'b1;
        sel(1'b0);
        wait_on(1, 1'b0, 8, c);
        cyc(2);
        chk(12'(eoc_n_q), 12'h0);
    endtask
    task automatic t_soft_rst();
        int c;
        u_sac_host_model.drive_hold(1'b0);
        cyc(20);
        cs_n = 1'b0;
        addr_bit_zero = 1'b0;
        cal_in = 1'b1;
        cyc(3);
        chk(12'(calibrating_q), 12'h1);
        chk(12'(converting_q), 12'h0);
        chk(12'(eoc_n_q), 12'h1);
        chk(12'(cal_bit_q), 12'h1);
        chk(12'(cal_trim_q), 12'(1 << (TRIM_W - 1)));
        cs_n = 1'b1;
        addr_bit_zero = 1'b1;
        u_sac_host_model.drive_hold(1'b1);
        wait_on(1, 1'b0, 6000, c);
        cyc(2);
        chk(12'(eoc_n_q), 12'h0);
        chk(12'(tracking_switch_q), 12'h1);
    endtask
    initial begin
        logic [11:0] codes [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
        n_fail = 0;
        num_checks = 0;
        rst_b = 1'b0;
        ext_en = 1'b0;
        cs_n = 1'b1;
        addr_bit_zero = 1'b1;
        cal_in = 1'b0;
        interleave_ctl_n = 1'b1;
        bipolar_mode = 1'b0;
        over_range_hi = 1'b0;
        under_range_lo = 1'b0;
        vin = 12'h000;
        cyc(4);
        rst_b = 1'b1;
        cyc(2);
        t_start();
        t_conv(12'h5A3, 1'b0, 1'b0, 1'b0, 12'h5A3, 32);
        ext_en = 1'b1;
        cyc(40);
        foreach (codes[i]) t_conv(codes[i], 1'b0, 1'b0, 1'b0, codes[i], 4);
        t_conv(12'h3C1, 1'b1, 1'b0, 1'b0, 12'h3C1, 4);
        t_conv(12'h123, 1'b0, 1'b1, 1'b0, 12'hFFF, 4);
        t_conv(12'h123, 1'b0, 1'b0, 1'b1, 12'h000, 4);
        t_conv(12'h123, 1'b1, 1'b1, 1'b1, 12'hFFF, 4);
        t_reconv();
        t_cal_sel();
        t_soft_rst();
        close_out();
    end
endmodule
